// file: backlight_boost_and_string_control.sv
// Overview of operation
// RQ1: static sync level high enables spreading, low disables
// RQ2: sync clock drives boost, spreading forced off
// RQ3: lost sync clock: resistor frequency, level decides spreading
// RQ4: deviation code 00..11 = 3.3/4.3/5.3/7.2 percent
// RQ5: rate code 00..11 = 200/500/800/1200 Hz
// RQ6: enable low stops boost, sinks, powerline; discharges
// RQ7: discharge lasts 400 ms, then full shutdown
// RQ8: discharge overvoltage enters fault recovery, reports fault
// RQ9: light load skips switching cycles intermittently
// RQ10: per-string 12-bit current code, resets to all ones
// RQ11: first power-up decodes config, assigns channel phases
// RQ12: config fixed until passing through shutdown
// RQ13: independent channels spaced 60/72/90/120/180 degrees
// RQ14: grouped channels: pairs 120, triples 180, single none
// RQ15: sync is clock only while edges beat timeout
// RQ16: phase step equals dimming period over strings
`timescale 1ns/1ps
`default_nettype none
module backlight_boost_and_string_control
  import backlight_ctrl_pkg::*;
#(
  parameter int unsigned DISCHARGE_LEN = backlight_ctrl_pkg::DISCHARGE_CYCLES
) (
  // clock and reset
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset_n,
  // pins and analog status
  input  wire logic                                   enablePin,
  input  wire logic                                   boostClockSyncInput,
  input  wire logic                                   dischargeOverHigh,
  input  wire logic                                   lightLoadDetect,
  input  wire logic [2:0]                             stringConfigCode,
  input  wire logic [backlight_ctrl_pkg::DIM_W-1:0]   dimPeriodCycles,
  // register read and write port
  input  wire logic                                   regWrite,
  input  wire logic [2:0]                             regAddr,
  input  wire logic [11:0]                            regWrData,
  output logic      [11:0]                            regRdData,
  // boost controller
  output logic                                        boostRun,
  output logic                                        boostClkSelExt,
  output logic                                        spreadEnable,
  output logic      [6:0]                             spreadDevTenths,
  output logic      [10:0]                            spreadRateHz,
  output logic                                        boostSkipCycle,
  output logic                                        powerLineOn,
  output logic                                        dischargeOn,
  output logic                                        boostOvHighFault,
  // current sinks
  output logic      [5:0]                             sinkEnable,
  output logic      [5:0]                             sinkPhaseStart,
  output logic      [6*12-1:0]                        stringCurrentCodes
);

  power_state_t                 state_ff, nxt_state;
  logic [DISCHARGE_CNT_W-1:0]   dischCnt_ff;
  logic [1:0]                   spreadDev_ff, spreadRate_ff;
  logic [11:0]                  curCode_ff [NUM_SINKS];
  logic [2:0]                   config_ff;
  logic                         spread_ff, extSel_ff, skip_ff, fault_ff;
  logic [6:0]                   devTenths_ff;
  logic [10:0]                  rateHz_ff;
  logic [DIM_W-1:0]             dimCnt_ff;
  logic [5:0]                   phaseStart_ff;
  logic [11:0]                  rdData_ff;
  logic                         extClockPresent, staticLevel, levelSettled;

  sync_input_classifier u_sync (
    .sys_clk             (sys_clk),
    .reset_n             (reset_n),
    .boostClockSyncInput (boostClockSyncInput),
    .extClockPresent     (extClockPresent),
    .staticLevel         (staticLevel),
    .levelSettled        (levelSettled)
  );

  // power sequencing; a comparator trip outranks a falling enable so recovery starts at once
  wire running     = (state_ff == ST_ACTIVE);
  wire dischDone   = (dischCnt_ff == DISCHARGE_CNT_W'(DISCHARGE_LEN - 1));
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SHUTDOWN:  if (enablePin) nxt_state = ST_ACTIVE;
      ST_ACTIVE:    if (dischargeOverHigh) nxt_state = ST_FAULT; // RQ8
                    else if (!enablePin) nxt_state = ST_DISCHARGE; // RQ6
      ST_DISCHARGE: if (dischargeOverHigh) nxt_state = ST_FAULT; // RQ8
                    else if (dischDone) nxt_state = ST_SHUTDOWN; // RQ7
      ST_FAULT:     if (!enablePin && !dischargeOverHigh) nxt_state = ST_DISCHARGE;
      default:      nxt_state = ST_SHUTDOWN;
    endcase
  end

  // discharge timer counts only while discharging; 27 bits cover 400 ms
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff    <= ST_SHUTDOWN;
      dischCnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      dischCnt_ff <= (state_ff == ST_DISCHARGE) ? dischCnt_ff + DISCHARGE_CNT_W'(1) : '0; // RQ7
    end
  end

  // fault is sticky through recovery; only a fresh power-up clears it, and a new event wins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) fault_ff <= 1'b0;
    else if (dischargeOverHigh) fault_ff <= 1'b1; // RQ8
    else if (state_ff == ST_SHUTDOWN && enablePin) fault_ff <= 1'b0;
  end

  // string configuration latched only when leaving shutdown
  always_ff @(posedge sys_clk) begin
    if (!reset_n) config_ff <= CFG_SIX;
    else if (state_ff == ST_SHUTDOWN && enablePin) config_ff <= stringConfigCode; // RQ11 RQ12
  end

  // register file
  wire wrDev  = regWrite && (regAddr == REG_SPREAD_DEV);
  wire wrRate = regWrite && (regAddr == REG_SPREAD_RATE);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      spreadDev_ff  <= SPREAD_DEV_RESET; // RQ4
      spreadRate_ff <= SPREAD_RATE_RESET; // RQ5
    end else begin
      if (wrDev)  spreadDev_ff  <= regWrData[1:0];
      if (wrRate) spreadRate_ff <= regWrData[1:0];
    end
  end

  // per-string current codes and phase offsets
  logic [2:0]       strIdx  [NUM_SINKS];
  logic             chUsed  [NUM_SINKS];
  logic [DIM_W-1:0] offset  [NUM_SINKS];
  logic [DIM_W-1:0] phaseStep;
  logic [2:0]       nStrings;

  // number of strings sets the spacing; grouped channels share one phase
  always_comb begin
    case (config_ff)
      CFG_SIX:     nStrings = 3'h6; // RQ13
      CFG_FIVE:    nStrings = 3'h5;
      CFG_FOUR:    nStrings = 3'h4;
      CFG_THREE:   nStrings = 3'h3;
      CFG_TWO:     nStrings = 3'h2;
      CFG_PAIRS:   nStrings = 3'h3; // RQ14
      CFG_TRIPLES: nStrings = 3'h2;
      default:     nStrings = 3'h1;
    endcase
  end
  assign phaseStep = dimPeriodCycles / DIM_W'(nStrings); // RQ16

  genvar g;
  generate
    for (g = 0; g < NUM_SINKS; g++) begin : g_sink
      wire wrCur = regWrite && (regAddr == REG_STRING_CUR0 + 3'(g));
      always_ff @(posedge sys_clk) begin
        if (!reset_n) curCode_ff[g] <= STRING_CUR_RESET; // RQ10
        else if (wrCur) curCode_ff[g] <= regWrData; // RQ10
      end
      assign strIdx[g] = (config_ff == CFG_PAIRS)   ? 3'(g / 2) :
                         (config_ff == CFG_TRIPLES) ? 3'(g / 3) :
                         (config_ff == CFG_SINGLE)  ? 3'h0 : 3'(g); // RQ14
      assign chUsed[g] = (config_ff >= CFG_PAIRS) || (3'(g) < nStrings); // RQ13
      assign offset[g] = DIM_W'(phaseStep * strIdx[g]); // RQ16
      assign stringCurrentCodes[g*12 +: 12] = curCode_ff[g];
      assign sinkEnable[g] = running && chUsed[g]; // RQ6
    end
  endgenerate

  // dimming period counter and phase-start pulses
  wire dimWrap = (dimCnt_ff >= dimPeriodCycles - DIM_W'(1));
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !running) dimCnt_ff <= '0;
    else dimCnt_ff <= dimWrap ? '0 : dimCnt_ff + DIM_W'(1);
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) phaseStart_ff <= '0;
    else for (int i = 0; i < NUM_SINKS; i++)
      phaseStart_ff[i] <= running && chUsed[i] && (dimCnt_ff == offset[i]); // RQ13 RQ14
  end

  // boost clock mode: external clock wins, otherwise settled level picks spreading
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      spread_ff <= 1'b0;
      extSel_ff <= 1'b0;
      skip_ff   <= 1'b0;
    end else begin
      extSel_ff <= extClockPresent; // RQ2 RQ3
      if (extClockPresent) spread_ff <= 1'b0; // RQ2
      else if (levelSettled) spread_ff <= staticLevel; // RQ1 RQ3
      // alternate skipping keeps the output from creeping up at light load
      skip_ff <= (lightLoadDetect && running) ? ~skip_ff : 1'b0; // RQ9
    end
  end

  // decoded spreading settings and readback
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      devTenths_ff <= DEV_TENTHS_10;
      rateHz_ff    <= RATE_HZ_00;
      rdData_ff    <= '0;
    end else begin
      case (spreadDev_ff) // RQ4
        2'h0:    devTenths_ff <= DEV_TENTHS_00;
        2'h1:    devTenths_ff <= DEV_TENTHS_01;
        2'h2:    devTenths_ff <= DEV_TENTHS_10;
        default: devTenths_ff <= DEV_TENTHS_11;
      endcase
      case (spreadRate_ff) // RQ5
        2'h0:    rateHz_ff <= RATE_HZ_00;
        2'h1:    rateHz_ff <= RATE_HZ_01;
        2'h2:    rateHz_ff <= RATE_HZ_10;
        default: rateHz_ff <= RATE_HZ_11;
      endcase
      if (regAddr == REG_SPREAD_DEV)       rdData_ff <= {10'h000, spreadDev_ff};
      else if (regAddr == REG_SPREAD_RATE) rdData_ff <= {10'h000, spreadRate_ff};
      else                                 rdData_ff <= curCode_ff[3'(regAddr - REG_STRING_CUR0)];
    end
  end

  assign regRdData        = rdData_ff;
  assign boostRun         = running; // RQ6
  assign powerLineOn      = running; // RQ6
  assign dischargeOn      = (state_ff == ST_DISCHARGE); // RQ6 RQ7
  assign boostOvHighFault = fault_ff;
  assign boostClkSelExt   = extSel_ff;
  assign spreadEnable     = spread_ff && !extSel_ff;
  assign spreadDevTenths  = devTenths_ff;
  assign spreadRateHz     = rateHz_ff;
  assign boostSkipCycle   = skip_ff;
  assign sinkPhaseStart   = phaseStart_ff;

  // checks
  property p_level_spread;
    @(posedge sys_clk) disable iff (!reset_n)
      (!extClockPresent && levelSettled) |=> ##1 (spreadEnable == $past(staticLevel, 2));
  endproperty
  a_level_spread: assert property (p_level_spread) else $error("spread not following level"); // RQ1

  property p_ext_no_spread;
    @(posedge sys_clk) disable iff (!reset_n) extClockPresent |=> (boostClkSelExt && !spreadEnable);
  endproperty
  a_ext_no_spread: assert property (p_ext_no_spread) else $error("spread on with external clock"); // RQ2

  property p_fallback;
    @(posedge sys_clk) disable iff (!reset_n) $fell(extClockPresent) |=> !boostClkSelExt;
  endproperty
  a_fallback: assert property (p_fallback) else $error("external clock kept after loss"); // RQ3

  property p_dev_decode;
    @(posedge sys_clk) disable iff (!reset_n) (spreadDev_ff == 2'h3) |=> (spreadDevTenths == 7'h48);
  endproperty
  a_dev_decode: assert property (p_dev_decode) else $error("deviation decode wrong"); // RQ4

  property p_rate_decode;
    @(posedge sys_clk) disable iff (!reset_n) (spreadRate_ff == 2'h1) |=> (spreadRateHz == 11'h1f4);
  endproperty
  a_rate_decode: assert property (p_rate_decode) else $error("rate decode wrong"); // RQ5

  property p_enable_low;
    @(posedge sys_clk) disable iff (!reset_n)
      (running && !enablePin && !dischargeOverHigh) |=>
        (!boostRun && sinkEnable == 6'h00 && !powerLineOn && dischargeOn);
  endproperty
  a_enable_low: assert property (p_enable_low) else $error("enable low did not stop outputs"); // RQ6

  property p_discharge_end;
    @(posedge sys_clk) disable iff (!reset_n)
      (dischargeOn && dischDone && !dischargeOverHigh) |=> (state_ff == ST_SHUTDOWN && !dischargeOn);
  endproperty
  a_discharge_end: assert property (p_discharge_end) else $error("discharge did not end"); // RQ7

  property p_ovh;
    @(posedge sys_clk) disable iff (!reset_n)
      (dischargeOverHigh && state_ff != ST_SHUTDOWN) |=> (boostOvHighFault && state_ff == ST_FAULT);
  endproperty
  a_ovh: assert property (p_ovh) else $error("overvoltage fault missed"); // RQ8

  property p_skip;
    @(posedge sys_clk) disable iff (!reset_n) (skip_ff && lightLoadDetect && running) |=> !skip_ff;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not intermittent"); // RQ9

  property p_cur_write;
    @(posedge sys_clk) disable iff (!reset_n)
      (regWrite && regAddr == REG_STRING_CUR0) |=> (stringCurrentCodes[11:0] == $past(regWrData));
  endproperty
  a_cur_write: assert property (p_cur_write) else $error("current code not written"); // RQ10

  property p_config_fixed;
    @(posedge sys_clk) disable iff (!reset_n) (state_ff != ST_SHUTDOWN) |=> $stable(config_ff);
  endproperty
  a_config_fixed: assert property (p_config_fixed) else $error("config changed while powered"); // RQ12

  property p_unused_off;
    @(posedge sys_clk) disable iff (!reset_n) (config_ff == CFG_TWO) |-> (sinkEnable[5:2] == 4'h0);
  endproperty
  a_unused_off: assert property (p_unused_off) else $error("unused sink enabled"); // RQ13

  property p_single_phase;
    @(posedge sys_clk) disable iff (!reset_n)
      (config_ff == CFG_SINGLE && running && dimCnt_ff == '0) |=> (sinkPhaseStart == 6'h3f);
  endproperty
  a_single_phase: assert property (p_single_phase) else $error("single string not in phase"); // RQ14

  c_discharge: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(dischargeOn));
  c_ext_sync:  cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(boostClkSelExt));
  c_fault:     cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(boostOvHighFault));
  c_pairs:     cover property (@(posedge sys_clk) disable iff (!reset_n) running && config_ff == CFG_PAIRS);

endmodule // backlight_boost_and_string_control
`default_nettype wire

// file: backlight_ctrl_pkg.sv
package backlight_ctrl_pkg;

  // clock rate and timing
  localparam int unsigned SYS_CLK_KHZ        = 250000;
  localparam int unsigned DISCHARGE_TIME_MS  = 400;
  localparam int unsigned DISCHARGE_CYCLES   = DISCHARGE_TIME_MS * SYS_CLK_KHZ;
  localparam int unsigned DISCHARGE_CNT_W    = 27;
  // slowest legal sync clock is 100 kHz: 10 us period; allow 12 us between edges
  localparam int unsigned SYNC_TIMEOUT_US    = 12;
  localparam int unsigned SYNC_TIMEOUT_CYC   = SYNC_TIMEOUT_US * (SYS_CLK_KHZ / 1000);
  localparam int unsigned SYNC_TIMER_W       = 12;
  localparam logic [1:0]  SYNC_EDGES_NEEDED  = 2'h2;

  // register indices on the write port
  localparam logic [2:0] REG_SPREAD_DEV      = 3'h0;
  localparam logic [2:0] REG_SPREAD_RATE     = 3'h1;
  localparam logic [2:0] REG_STRING_CUR0     = 3'h2;

  // reset values
  localparam logic [1:0]  SPREAD_DEV_RESET   = 2'h2;
  localparam logic [1:0]  SPREAD_RATE_RESET  = 2'h0;
  localparam logic [11:0] STRING_CUR_RESET   = 12'hfff;

  localparam int unsigned NUM_SINKS          = 6;
  localparam int unsigned DIM_W              = 17;

  // deviation in tenths of a percent, modulation rate in Hz
  localparam logic [6:0]  DEV_TENTHS_00      = 7'h21; // 3.3 %
  localparam logic [6:0]  DEV_TENTHS_01      = 7'h2b; // 4.3 %
  localparam logic [6:0]  DEV_TENTHS_10      = 7'h35; // 5.3 %
  localparam logic [6:0]  DEV_TENTHS_11      = 7'h48; // 7.2 %
  localparam logic [10:0] RATE_HZ_00         = 11'h0c8; // 200
  localparam logic [10:0] RATE_HZ_01         = 11'h1f4; // 500
  localparam logic [10:0] RATE_HZ_10         = 11'h320; // 800
  localparam logic [10:0] RATE_HZ_11         = 11'h4b0; // 1200

  // string configuration codes, in resistor order
  localparam logic [2:0] CFG_SIX            = 3'h0;
  localparam logic [2:0] CFG_FIVE           = 3'h1;
  localparam logic [2:0] CFG_FOUR           = 3'h2;
  localparam logic [2:0] CFG_THREE          = 3'h3;
  localparam logic [2:0] CFG_TWO            = 3'h4;
  localparam logic [2:0] CFG_PAIRS          = 3'h5;
  localparam logic [2:0] CFG_TRIPLES        = 3'h6;
  localparam logic [2:0] CFG_SINGLE         = 3'h7;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_ACTIVE,
    ST_DISCHARGE,
    ST_FAULT
  } power_state_t;

endpackage

// file: boost_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural boost stage seen from the control block
module boost_stage_model (
  // device controls
  input  wire logic sys_clk,
  input  wire logic boostRun,
  input  wire logic powerLineOn,
  input  wire logic dischargeOn,
  // bench requests
  input  wire logic overVoltReq,
  input  wire logic lightLoadReq,
  // status back to the device
  output logic      dischargeOverHigh,
  output logic      lightLoadDetect
);
  logic outCharged_ff = 1'b0;

  // output holds charge until the discharge path bleeds it, so the
  // comparator can still trip after the boost has stopped
  always_ff @(posedge sys_clk) begin
    if (boostRun && powerLineOn) begin
      outCharged_ff <= 1'b1;
    end else if (dischargeOn) begin
      outCharged_ff <= 1'b0;
    end
  end

  // a stopped converter cannot be in light load
  assign dischargeOverHigh = overVoltReq & outCharged_ff;
  assign lightLoadDetect   = lightLoadReq & boostRun;
endmodule // boost_stage_model
`default_nettype wire

// file: sync_input_classifier.sv
`timescale 1ns/1ps
`default_nettype none
module sync_input_classifier
  import backlight_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // sync pin
  input  wire logic boostClockSyncInput,
  // classification
  output logic      extClockPresent,
  output logic      staticLevel,
  output logic      levelSettled
);

  logic                    syncPrev_ff;
  logic [SYNC_TIMER_W-1:0] timer_ff;
  logic [1:0]              edgeCnt_ff;
  logic                    clkPres_ff;
  logic                    level_ff;
  logic                    settled_ff;

  wire edgeSeen = boostClockSyncInput ^ syncPrev_ff;
  wire timedOut = (timer_ff == SYNC_TIMER_W'(SYNC_TIMEOUT_CYC));

  // edges inside the window keep the clock verdict; a quiet window drops it
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      syncPrev_ff <= 1'b0;
      timer_ff    <= '0;
      edgeCnt_ff  <= '0;
      clkPres_ff  <= 1'b0;
      level_ff    <= 1'b0;
      settled_ff  <= 1'b0;
    end else begin
      syncPrev_ff <= boostClockSyncInput;
      if (edgeSeen) begin
        timer_ff   <= '0;
        settled_ff <= 1'b0;
        if (edgeCnt_ff != SYNC_EDGES_NEEDED) edgeCnt_ff <= edgeCnt_ff + 2'h1;
        else clkPres_ff <= 1'b1; // RQ15
      end else if (timedOut) begin
        edgeCnt_ff <= '0;
        clkPres_ff <= 1'b0; // RQ15
        settled_ff <= 1'b1;
        level_ff   <= boostClockSyncInput;
      end else begin
        timer_ff <= timer_ff + SYNC_TIMER_W'(1);
      end
    end
  end

  assign extClockPresent = clkPres_ff;
  assign staticLevel     = level_ff;
  assign levelSettled    = settled_ff;

  property p_timeout_drops_clock;
    @(posedge sys_clk) disable iff (!reset_n)
      (timedOut && !edgeSeen) |=> (!clkPres_ff && settled_ff);
  endproperty
  a_timeout_drops_clock: assert property (p_timeout_drops_clock) else $error("sync timeout kept clock"); // RQ15

endmodule // sync_input_classifier
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import backlight_ctrl_pkg::*;
  localparam int unsigned DLEN = 50; // short discharge keeps the run brief

  logic             sys_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             enablePin = 1'b0;
  logic             syncPin = 1'b0;
  logic             overVoltReq = 1'b0;
  logic             lightLoadReq = 1'b0;
  logic [2:0]       cfgCode = 3'h0;
  logic [DIM_W-1:0] dimCycles = 17'h00258;
  logic             regWrite = 1'b0;
  logic [2:0]       regAddr = 3'h0;
  logic [11:0]      regWrData = 12'h000;
  logic [11:0]      regRdData;
  logic             dischargeOverHigh, lightLoadDetect, boostRun, boostClkSelExt, spreadEnable;
  logic             boostSkipCycle, powerLineOn, dischargeOn, boostOvHighFault;
  logic [6:0]       spreadDevTenths;
  logic [10:0]      spreadRateHz;
  logic [5:0]       sinkEnable, sinkPhaseStart;
  logic [71:0]      stringCurrentCodes;
  int               failures = 0;
  int               total_checks = 0;

  always #2 sys_clk = ~sys_clk;

  backlight_boost_and_string_control #(.DISCHARGE_LEN(DLEN)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .enablePin(enablePin), .boostClockSyncInput(syncPin),
    .dischargeOverHigh(dischargeOverHigh), .lightLoadDetect(lightLoadDetect), .stringConfigCode(cfgCode),
    .dimPeriodCycles(dimCycles), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .boostRun(boostRun), .boostClkSelExt(boostClkSelExt), .spreadEnable(spreadEnable),
    .spreadDevTenths(spreadDevTenths), .spreadRateHz(spreadRateHz), .boostSkipCycle(boostSkipCycle),
    .powerLineOn(powerLineOn), .dischargeOn(dischargeOn), .boostOvHighFault(boostOvHighFault),
    .sinkEnable(sinkEnable), .sinkPhaseStart(sinkPhaseStart), .stringCurrentCodes(stringCurrentCodes));

  boost_stage_model i_stage (
    .sys_clk(sys_clk), .boostRun(boostRun), .powerLineOn(powerLineOn), .dischargeOn(dischargeOn),
    .overVoltReq(overVoltReq), .lightLoadReq(lightLoadReq), .dischargeOverHigh(dischargeOverHigh),
    .lightLoadDetect(lightLoadDetect));

  // expectations, worked out from the decode tables
  function automatic logic [6:0] devExp(input int c);
    case (c)
      0: return 7'h21;
      1: return 7'h2b;
      2: return 7'h35;
      default: return 7'h48;
    endcase
  endfunction
  function automatic logic [10:0] rateExp(input int c);
    case (c)
      0: return 11'h0c8;
      1: return 11'h1f4;
      2: return 11'h320;
      default: return 11'h4b0;
    endcase
  endfunction
  function automatic logic [5:0] expEn(input int c);
    return (c < 5) ? 6'h3f >> c : 6'h3f;
  endfunction
  // -1 means the channel must never pulse
  function automatic int expOff(input int c, input int k, input int dim);
    int n;
    int idx;
    n = (c < 5) ? 6 - c : 8 - c;
    idx = (c < 5) ? k : (c == 5) ? k / 2 : (c == 6) ? k / 3 : 0;
    if (c < 5 && k >= n) return -1;
    return (dim / n) * idx;
  endfunction

  // inputs always move 1 ns after the edge so nothing races the sampling
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chkVal(input string what, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chkCnt(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic timedOut(input string what);
    failures++;
    $display("MISMATCH %s expected event seen timeout", what);
    close_out();
  endtask
  // strobe drops with an idle edge after it, so calls may follow directly
  task automatic wrReg(input logic [2:0] a, input logic [11:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    tick();
    regWrite = 1'b0;
    tick();
  endtask
  task automatic rdReg(input logic [2:0] a, input logic [11:0] exp);
    regAddr = a;
    tick();
    chkVal("regRdData", 72'(exp), 72'(regRdData));
  endtask
  task automatic powerUp(input logic [2:0] c);
    cfgCode = c;
    enablePin = 1'b1;
    tick(2);
    chkVal("boostRun", 1, boostRun);
    chkVal("powerLineOn", 1, powerLineOn);
  endtask
  task automatic powerDown();
    enablePin = 1'b0;
    tick(2);
    chkVal("dischargeOn", 1, dischargeOn);
    chkVal("offOutputs", 0, {boostRun, powerLineOn, sinkEnable});
    tick(DLEN - 8);
    chkVal("dischargeHeld", 1, dischargeOn);
    tick(10);
    chkVal("dischargeEnd", 0, dischargeOn);
  endtask

  initial begin
    int w, c, k, ones, h;
    int first[6];
    logic [11:0] cur[6];
    logic [71:0] allCur;
    void'($urandom(32'heb583862));
    tick(4);
    reset_n = 1'b1;
    tick();
    chkVal("devTenths", 72'h35, 72'(spreadDevTenths));
    chkVal("rateHz", 72'h0c8, 72'(spreadRateHz));
    chkVal("codes", {6{12'hfff}}, stringCurrentCodes);
    rdReg(REG_SPREAD_DEV, 12'h002);
    rdReg(REG_SPREAD_RATE, 12'h000);
    for (k = 0; k < 6; k++) rdReg(REG_STRING_CUR0 + 3'(k), 12'hfff);
    $display("test reset values done");
    // every deviation and rate code; junk upper bits must be dropped
    for (c = 0; c < 4; c++) begin
      wrReg(REG_SPREAD_DEV, 12'hffc | 12'(c));
      wrReg(REG_SPREAD_RATE, {10'h155, 2'(3 - c)});
      tick();
      chkVal("devTenths", 72'(devExp(c)), 72'(spreadDevTenths));
      chkVal("rateHz", 72'(rateExp(3 - c)), 72'(spreadRateHz));
      rdReg(REG_SPREAD_DEV, 12'(c));
    end
    $display("test spread decode done");
    // random codes, with the zero code as a corner on the last string
    for (k = 0; k < 6; k++) begin
      cur[k] = (k == 5) ? 12'h000 : 12'($urandom);
      allCur[12*k+:12] = cur[k];
      wrReg(REG_STRING_CUR0 + 3'(k), cur[k]);
      rdReg(REG_STRING_CUR0 + 3'(k), cur[k]);
    end
    chkVal("codes", allCur, stringCurrentCodes);
    $display("test current codes done");
    // each configuration: enables, phase offsets, lock while active, shutdown
    for (c = 0; c < 8; c++) begin
      dimCycles = 17'(300 + $urandom % 300);
      powerUp(3'(c));
      chkVal("sinkEnable", 72'(expEn(c)), 72'(sinkEnable));
      w = 0;
      while (sinkPhaseStart[0] !== 1'b1) begin
        if (w++ > 1300) timedOut("phaseStart");
        tick();
      end
      for (k = 0; k < 6; k++) first[k] = (sinkPhaseStart[k] === 1'b1) ? 0 : -1;
      for (w = 1; w < int'(dimCycles); w++) begin
        tick();
        for (k = 0; k < 6; k++) if (first[k] < 0 && sinkPhaseStart[k] === 1'b1) first[k] = w;
      end
      for (k = 0; k < 6; k++) chkCnt("phaseOffset", expOff(c, k, int'(dimCycles)), first[k]);
      cfgCode = ~cfgCode;
      tick(3);
      chkVal("sinkEnableLocked", 72'(expEn(c)), 72'(sinkEnable));
      powerDown();
    end
    $display("test configurations done");
    // overvoltage on the output trips fault recovery
    powerUp(3'h0);
    overVoltReq = 1'b1;
    w = 0;
    while (boostOvHighFault !== 1'b1) begin
      if (w++ > 8) timedOut("ovFault");
      tick();
    end
    tick(2);
    chkVal("faultOff", 0, {boostRun, sinkEnable});
    overVoltReq = 1'b0;
    powerDown();
    powerUp(3'h0);
    chkVal("faultClear", 0, boostOvHighFault);
    $display("test overvoltage done");
    // light load: alternate switching cycles skipped, none otherwise
    lightLoadReq = 1'b1;
    for (h = 2; h >= 0; h -= 2) begin
      tick(3);
      ones = 0;
      repeat (4) begin
        ones += int'(boostSkipCycle === 1'b1);
        tick();
      end
      chkCnt("skipCount", h, ones);
      lightLoadReq = 1'b0;
    end
    $display("test light load done");
    // static levels, then fastest and slowest sync clock and its loss
    tick(3100);
    chkVal("spreadLow", 0, spreadEnable);
    syncPin = 1'b1;
    for (h = 57; h <= 1250; h += 1193) begin
      tick(3100);
      chkVal("spreadHigh", 1, spreadEnable);
      chkVal("selExtLevel", 0, boostClkSelExt);
      repeat (8) begin
        syncPin = ~syncPin;
        tick(h);
      end
      chkVal("selExtClock", 1, boostClkSelExt);
      chkVal("spreadForcedOff", 0, spreadEnable);
    end
    syncPin = 1'b0;
    tick(3100);
    chkVal("spreadAfterLoss", 0, {boostClkSelExt, spreadEnable});
    powerDown();
    $display("test sync pin done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
